// *** core/ptcc_top.sv ***
// Purpose: Control/status registers and counter of one 16-bit up/down timer channel
// Assumes: All inputs synchronous to pclk; source inputs are levels sampled each pclk
// Notes:   APB slave answers with no wait state; counter ticks are pclk enables
// Function
// - Debug-run bit keeps channel clock in debug
// - Three-bit field selects counter clock source
// - Divider is two to the field value for RC and high-speed sources
// - Absent clock sources cannot be selected
// - Max-load-pending reads 1 during max transfer
// - Direction field and single-pass bit select mode
// - Run bit starts, stops, reads counting state
// - One-shot end clears run bit itself
// - Preload clears counter, or loads max downward
// - Preload bit reads 1 while reset pending
// - Channel enable gates clock, preload, run start
// - Maximum register resets to all ones
// - Counter value register reads live count
// - Status bits mirror capture pin levels
// - Direction status reads 1 when counting up
// - Active status reads 1 while operating
// - Absent capture pins read as 0
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ptcc_top
  import ptcc_pkg::*;
#(
  parameter logic [7:0] SRC_PRESENT = 8'hFF,
  parameter logic [5:0] CAP_PRESENT = 6'h3F
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock sources and system state
  input  wire logic        internal_rc_oscillator,
  input  wire logic        low_speed_oscillator,
  input  wire logic        high_speed_oscillator,
  input  wire logic        external_clock_source,
  input  wire logic        external_count_input_0,
  input  wire logic        external_count_input_1,
  input  wire logic        debug_mode,
  // Capture pins
  input  wire logic [5:0]  capture_input_pin,
  // Channel outputs
  output logic             channel_clock_gate,
  output logic             counter_max_pulse,
  output logic             counter_zero_pulse
);

  function automatic logic [14:0] div_mask(input logic [3:0] n);
    div_mask = 15'((16'h0001 << n) - 16'h0001);
  endfunction

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
    is_addr = (a == off);
  endfunction

  logic [2:0]  clock_source_select_r;
  logic [3:0]  clock_divide_select_r;
  logic        debug_run_enable_r;
  logic        channel_enable_r;
  logic        run_r;
  logic        preload_r;
  logic        single_pass_select_r;
  logic [1:0]  count_direction_select_r;
  logic [15:0] max_count_value_r;
  logic [15:0] max_stage_r;
  logic [15:0] counter_value_field_r;
  logic        dir_up_r;
  logic        src_prev_r;
  logic [14:0] presc_r;
  logic [1:0]  ml_cnt_r;
  ptcc_mload_t ml_state_r;

  logic        wr_acc;
  logic        setup;
  logic        en_nxt;
  logic        clk_ok;
  logic        src_lvl;
  logic        src_edge;
  logic [3:0]  eff_div;
  logic        cnt_tick;
  logic        at_max;
  logic        at_zero;
  logic        max_busy;
  logic        active;
  logic        mapped;
  logic [31:0] rd_nxt;

  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pready && pwrite;
  assign en_nxt   = (wr_acc && is_addr(paddr, OFF_COUNTER_CONTROL)) ? pwdata[CH_EN_BIT]
                                                                   : channel_enable_r;
  assign clk_ok   = channel_enable_r && (!debug_mode || debug_run_enable_r);
  assign max_busy = (ml_state_r != ML_IDLE);
  assign active   = run_r || max_busy;
  assign at_max   = (counter_value_field_r == max_count_value_r);
  assign at_zero  = (counter_value_field_r == CNT_RESET);

  // Source selection; inverted inputs count on the falling edge
  always_comb begin
    unique case (clock_source_select_r)
      SRC_IRC:   src_lvl = internal_rc_oscillator;
      SRC_LOW:   src_lvl = low_speed_oscillator;
      SRC_HIGH:  src_lvl = high_speed_oscillator;
      SRC_EXT:   src_lvl = external_clock_source;
      SRC_IN0:   src_lvl = external_count_input_0;
      SRC_IN1:   src_lvl = external_count_input_1;
      SRC_IN0_N: src_lvl = !external_count_input_0;
      SRC_IN1_N: src_lvl = !external_count_input_1;
    endcase
  end

  // Low-speed source stops dividing past 1/256 and is undivided at the top code
  always_comb begin
    unique case (clock_source_select_r)
      SRC_IRC, SRC_HIGH: eff_div = clock_divide_select_r;
      SRC_LOW: begin
        if (clock_divide_select_r == DIV_NONE) begin
          eff_div = 4'h0;
        end else if (clock_divide_select_r > DIV_LOW_LIMIT) begin
          eff_div = DIV_LOW_LIMIT;
        end else begin
          eff_div = clock_divide_select_r;
        end
      end
      default: eff_div = 4'h0;
    endcase
  end

  assign src_edge = src_lvl && !src_prev_r;
  assign cnt_tick = src_edge && clk_ok && run_r &&
                    ((presc_r & div_mask(eff_div)) == div_mask(eff_div));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_r <= 1'b0;
      presc_r    <= 15'h0000;
    end else begin
      src_prev_r <= src_lvl;
      if (src_edge && clk_ok && run_r) begin
        presc_r <= presc_r + 15'h0001;
      end
    end
  end

  // clock_control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select_r <= SRC_IRC;
      clock_divide_select_r <= 4'h0;
      debug_run_enable_r    <= 1'b0;
    end else if (wr_acc && is_addr(paddr, OFF_CLOCK_CONTROL)) begin
      if (SRC_PRESENT[pwdata[CLK_SRC_LSB +: 3]]) begin
        clock_source_select_r <= pwdata[CLK_SRC_LSB +: 3];
      end
      clock_divide_select_r <= pwdata[CLK_DIV_LSB +: 4];
      debug_run_enable_r    <= pwdata[DBG_RUN_BIT];
    end
  end

  // counter_control mode bits and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_r         <= 1'b0;
      single_pass_select_r     <= 1'b0;
      count_direction_select_r <= DIR_UP;
    end else if (wr_acc && is_addr(paddr, OFF_COUNTER_CONTROL)) begin
      channel_enable_r         <= pwdata[CH_EN_BIT];
      single_pass_select_r     <= pwdata[ONE_SHOT_BIT];
      count_direction_select_r <= pwdata[DIR_LSB +: 2];
    end
  end

  // Run bit; software start needs enable, one-shot end clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else if (wr_acc && is_addr(paddr, OFF_COUNTER_CONTROL)) begin
      run_r <= pwdata[RUN_BIT] && en_nxt;
    end else if (cnt_tick && single_pass_select_r) begin
      if ((count_direction_select_r == DIR_UP && at_max) ||
          (count_direction_select_r != DIR_UP && at_zero && !dir_up_r)) begin
        run_r <= 1'b0;
      end
    end
  end

  // Preload request, held one cycle so it reads back as in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preload_r <= 1'b0;
    end else begin
      preload_r <= wr_acc && is_addr(paddr, OFF_COUNTER_CONTROL) &&
                   pwdata[PRELOAD_BIT] && en_nxt;
    end
  end

  // Maximum value: staged on write, copied after a fixed delay while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_stage_r       <= MAX_RESET;
      max_count_value_r <= MAX_RESET;
      ml_state_r        <= ML_IDLE;
      ml_cnt_r          <= 2'h0;
    end else begin
      unique case (ml_state_r)
        ML_IDLE: begin
          if (wr_acc && is_addr(paddr, OFF_MAXIMUM_COUNT)) begin
            max_stage_r <= pwdata[15:0];
            ml_cnt_r    <= 2'h0;
            ml_state_r  <= ML_WAIT;
          end
        end
        ML_WAIT: begin
          if (channel_enable_r) begin
            if (ml_cnt_r == 2'(MAX_LOAD_CYCLES - 1)) begin
              ml_state_r <= ML_COPY;
            end else begin
              ml_cnt_r <= ml_cnt_r + 2'h1;
            end
          end
        end
        ML_COPY: begin
          max_count_value_r <= max_stage_r;
          ml_state_r        <= ML_IDLE;
        end
      endcase
    end
  end

  // Counter and direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_field_r <= CNT_RESET;
      dir_up_r              <= 1'b1;
    end else if (preload_r) begin
      if (count_direction_select_r == DIR_DOWN) begin
        counter_value_field_r <= max_count_value_r;
        dir_up_r              <= 1'b0;
      end else begin
        counter_value_field_r <= CNT_RESET;
        dir_up_r              <= 1'b1;
      end
    end else if (cnt_tick) begin
      unique case (count_direction_select_r)
        DIR_UP: begin
          dir_up_r <= 1'b1;
          if (at_max) begin
            if (!single_pass_select_r) counter_value_field_r <= CNT_RESET;
          end else begin
            counter_value_field_r <= counter_value_field_r + 16'h0001;
          end
        end
        DIR_DOWN: begin
          dir_up_r <= 1'b0;
          if (at_zero) begin
            if (!single_pass_select_r) counter_value_field_r <= max_count_value_r;
          end else begin
            counter_value_field_r <= counter_value_field_r - 16'h0001;
          end
        end
        DIR_UPDOWN: begin
          if (dir_up_r && at_max) begin
            dir_up_r              <= 1'b0;
            counter_value_field_r <= counter_value_field_r - 16'h0001;
          end else if (!dir_up_r && at_zero) begin
            if (!single_pass_select_r) begin
              dir_up_r              <= 1'b1;
              counter_value_field_r <= counter_value_field_r + 16'h0001;
            end
          end else if (dir_up_r) begin
            counter_value_field_r <= counter_value_field_r + 16'h0001;
          end else begin
            counter_value_field_r <= counter_value_field_r - 16'h0001;
          end
        end
        // Reserved direction code holds the count
        default: counter_value_field_r <= counter_value_field_r;
      endcase
    end
  end

  // Read mux; unused upper bits are constant zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      OFF_CLOCK_CONTROL: begin
        rd_nxt[CLK_SRC_LSB +: 3] = clock_source_select_r;
        rd_nxt[CLK_DIV_LSB +: 4] = clock_divide_select_r;
        rd_nxt[DBG_RUN_BIT]      = debug_run_enable_r;
      end
      OFF_COUNTER_CONTROL: begin
        rd_nxt[CH_EN_BIT]    = channel_enable_r;
        rd_nxt[PRELOAD_BIT]  = preload_r;
        rd_nxt[RUN_BIT]      = run_r;
        rd_nxt[ONE_SHOT_BIT] = single_pass_select_r;
        rd_nxt[DIR_LSB +: 2] = count_direction_select_r;
        rd_nxt[MAX_BUSY_BIT] = max_busy;
      end
      OFF_MAXIMUM_COUNT: rd_nxt[15:0] = max_count_value_r;
      OFF_COUNTER_VALUE: rd_nxt[15:0] = counter_value_field_r;
      OFF_COUNTER_STATUS: begin
        rd_nxt[CAP_LSB +: 6] = capture_input_pin & CAP_PRESENT;
        rd_nxt[UPDOWN_BIT]   = dir_up_r;
        rd_nxt[ACTIVE_BIT]   = active;
      end
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: no wait state, read data sampled in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      end
    end
  end

  // Channel outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_clock_gate <= 1'b0;
      counter_max_pulse  <= 1'b0;
      counter_zero_pulse <= 1'b0;
    end else begin
      channel_clock_gate <= clk_ok;
      counter_max_pulse  <= cnt_tick && at_max;
      counter_zero_pulse <= cnt_tick && at_zero;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_dbg_gate;
    channel_enable_r && debug_mode && !debug_run_enable_r |=> !channel_clock_gate;
  endproperty
  a_dbg_gate: assert property (p_dbg_gate) else $error("clock supplied in debug");

  property p_src_present;
    SRC_PRESENT[clock_source_select_r];
  endproperty
  a_src_present: assert property (p_src_present) else $error("absent source selected");

  property p_max_load;
    wr_acc && is_addr(paddr, OFF_MAXIMUM_COUNT) && !max_busy && channel_enable_r
      |=> max_busy[*3] ##1 (!max_busy && max_count_value_r == $past(max_stage_r));
  endproperty
  a_max_load: assert property (p_max_load) else $error("max load timing wrong");

  property p_run_gate;
    wr_acc && is_addr(paddr, OFF_COUNTER_CONTROL) && !pwdata[CH_EN_BIT] |=> !run_r;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("run started disabled");

  property p_one_shot_end;
    cnt_tick && single_pass_select_r && count_direction_select_r == DIR_UP && at_max
      && !wr_acc && !preload_r |=> !run_r && $stable(counter_value_field_r);
  endproperty
  a_one_shot_end: assert property (p_one_shot_end) else $error("one-shot not ended");

  property p_preload_up;
    wr_acc && is_addr(paddr, OFF_COUNTER_CONTROL) && pwdata[PRELOAD_BIT] && en_nxt
      && pwdata[DIR_LSB +: 2] == DIR_UP
      |=> preload_r ##1 (!preload_r && counter_value_field_r == CNT_RESET);
  endproperty
  a_preload_up: assert property (p_preload_up) else $error("preload failed");

  property p_wrap_up;
    cnt_tick && !single_pass_select_r && count_direction_select_r == DIR_UP && at_max
      && !preload_r |=> counter_value_field_r == CNT_RESET;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("repeat up did not wrap");

  property p_count_up;
    cnt_tick && count_direction_select_r == DIR_UP && !at_max && !preload_r
      |=> counter_value_field_r == $past(counter_value_field_r) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("up count step wrong");

  property p_reserved_zero;
    pready |-> prdata[31:16] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_pready_one;
    setup |=> pready ##1 !pready;
  endproperty
  a_pready_one: assert property (p_pready_one) else $error("APB answer timing wrong");

  c_one_shot: cover property (cnt_tick && single_pass_select_r && at_max);
  c_updown: cover property (cnt_tick && count_direction_select_r == DIR_UPDOWN && at_max);
  c_max_load: cover property (ml_state_r == ML_COPY);
  c_slverr: cover property (pslverr);
endmodule
`default_nettype wire

// *** core/ptcc_pkg.sv ***
// Purpose: Constants for the timer channel control and status block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register offsets are byte addresses
package ptcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CLOCK_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_COUNTER_CONTROL = 8'h04;
  localparam logic [7:0] OFF_MAXIMUM_COUNT   = 8'h08;
  localparam logic [7:0] OFF_COUNTER_VALUE   = 8'h0C;
  localparam logic [7:0] OFF_COUNTER_STATUS  = 8'h10;
  // clock_control fields
  localparam int CLK_SRC_LSB   = 0;
  localparam int CLK_DIV_LSB   = 4;
  localparam int DBG_RUN_BIT   = 8;
  // counter_control fields
  localparam int CH_EN_BIT     = 0;
  localparam int PRELOAD_BIT   = 1;
  localparam int RUN_BIT       = 2;
  localparam int ONE_SHOT_BIT  = 3;
  localparam int DIR_LSB       = 4;
  localparam int MAX_BUSY_BIT  = 8;
  // counter_status fields
  localparam int ACTIVE_BIT    = 0;
  localparam int UPDOWN_BIT    = 1;
  localparam int CAP_LSB       = 2;
  // Clock source codes
  localparam logic [2:0] SRC_IRC   = 3'h0;
  localparam logic [2:0] SRC_LOW   = 3'h1;
  localparam logic [2:0] SRC_HIGH  = 3'h2;
  localparam logic [2:0] SRC_EXT   = 3'h3;
  localparam logic [2:0] SRC_IN0   = 3'h4;
  localparam logic [2:0] SRC_IN1   = 3'h5;
  localparam logic [2:0] SRC_IN0_N = 3'h6;
  localparam logic [2:0] SRC_IN1_N = 3'h7;
  localparam logic [3:0] DIV_LOW_LIMIT = 4'h8;
  localparam logic [3:0] DIV_NONE      = 4'hF;
  // Count directions
  localparam logic [1:0] DIR_UP     = 2'h0;
  localparam logic [1:0] DIR_DOWN   = 2'h1;
  localparam logic [1:0] DIR_UPDOWN = 2'h2;
  // Reset values
  localparam logic [15:0] MAX_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // Maximum value transfer from staging to working register
  localparam int MAX_LOAD_CYCLES = 2;
  typedef enum logic [1:0] {
    ML_IDLE = 2'b00,
    ML_WAIT = 2'b01,
    ML_COPY = 2'b11
  } ptcc_mload_t;
endpackage

// *** sim/test_ptcc_top.sv ***
// Purpose: Self-checking bench for the timer channel control and status block
// Assumes: Source code 7 and capture pin 5 are absent in this build
// Notes:   Count input 0 gives exact ticks; oscillator rates are checked in a window
`timescale 1ns/1ps
`default_nettype none
module test_ptcc_top
  import ptcc_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_irc;
  logic        osc_en;
  logic        osc_hs;
  logic        ext_in0;
  logic        debug_mode;
  logic [5:0]  cap_pins;
  logic        gate;
  logic        max_pulse;
  logic        zero_pulse;
  logic [31:0] rdat;
  logic        rerr;
  int          bad_count;
  int          check_count;
  int          cycles;
  int          n_max;
  int          n_zero;

  ptcc_top #(.SRC_PRESENT(8'h7F), .CAP_PRESENT(6'h1F)) ptcc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_rc_oscillator(osc_irc), .low_speed_oscillator(1'b0),
    .high_speed_oscillator(osc_hs), .external_clock_source(1'b0),
    .external_count_input_0(ext_in0), .external_count_input_1(1'b0),
    .debug_mode(debug_mode), .capture_input_pin(cap_pins),
    .channel_clock_gate(gate), .counter_max_pulse(max_pulse),
    .counter_zero_pulse(zero_pulse)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (osc_en) osc_irc <= ~osc_irc;
    // Free-running, so picking the wrong oscillator shows up as a rate error
    osc_hs <= ~osc_hs;
    if (max_pulse === 1'b1) n_max++;
    if (zero_pulse === 1'b1) n_zero++;
    if (cycles == 20000) begin
      bad_count++;
      $display("ERROR t=%0t bench timed out", $time);
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(rdat, exp, what);
  endtask

  task automatic settle;
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, OFF_COUNTER_CONTROL, 32'h0);
      if (rdat[MAX_BUSY_BIT] === 1'b0) break;
    end
  endtask

  // Enable first, then load the maximum (never zero), then preload
  task automatic arm(input logic [2:0] mode, input logic [15:0] mx);
    wr(OFF_COUNTER_CONTROL, 32'h1);
    wr(OFF_MAXIMUM_COUNT, {16'h0, mx});
    settle();
    wr(OFF_COUNTER_CONTROL, {26'h0, mode, 3'b011});
  endtask

  task automatic go(input logic [2:0] mode);
    wr(OFF_COUNTER_CONTROL, {26'h0, mode, 3'b101});
    n_max  = 0;
    n_zero = 0;
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_in0 <= 1'b1;
      @(posedge pclk);
      ext_in0 <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask

  task automatic rate(input int lo, input int hi);
    logic [15:0] a;
    apb(1'b0, OFF_COUNTER_VALUE, 32'h0);
    a = rdat[15:0];
    repeat (80) @(posedge pclk);
    apb(1'b0, OFF_COUNTER_VALUE, 32'h0);
    a = rdat[15:0] - a;
    check({31'h0, (a >= lo) && (a <= hi)}, 32'h1, "count rate");
  endtask

  task automatic t_reset;
    rd(OFF_CLOCK_CONTROL, 32'h0, "clock reset");
    rd(OFF_COUNTER_CONTROL, 32'h0, "control reset");
    rd(OFF_MAXIMUM_COUNT, 32'h0000FFFF, "max reset");
    rd(OFF_COUNTER_VALUE, 32'h0, "value reset");
    rd(OFF_COUNTER_STATUS, 32'h2, "status reset");
    rd(8'h14, 32'h0, "unmapped read");
    check({31'h0, rerr}, 32'h1, "unmapped error");
    $display("test reset done");
  endtask

  task automatic t_regs;
    // Code 7 is absent here, so the old source code must stay
    wr(OFF_CLOCK_CONTROL, 32'hFFFFFFFF);
    rd(OFF_CLOCK_CONTROL, 32'h000001F0, "clock reserved");
    wr(OFF_CLOCK_CONTROL, 32'h00000005);
    rd(OFF_CLOCK_CONTROL, 32'h00000005, "clock source");
    wr(OFF_COUNTER_VALUE, 32'h00001234);
    rd(OFF_COUNTER_VALUE, 32'h0, "value read only");
    cap_pins <= 6'h3F;
    rd(OFF_COUNTER_STATUS, 32'h0000007E, "capture levels");
    cap_pins <= 6'h2A;
    rd(OFF_COUNTER_STATUS, 32'h0000002A, "absent pin");
    $display("test registers done");
  endtask

  task automatic t_gate;
    wr(OFF_COUNTER_CONTROL, 32'h4);
    rd(OFF_COUNTER_CONTROL, 32'h0, "run without enable");
    debug_mode <= 1'b1;
    wr(OFF_CLOCK_CONTROL, 32'h0);
    wr(OFF_COUNTER_CONTROL, 32'h1);
    repeat (3) @(posedge pclk);
    check({31'h0, gate}, 32'h0, "debug stop");
    wr(OFF_CLOCK_CONTROL, 32'h100);
    repeat (3) @(posedge pclk);
    check({31'h0, gate}, 32'h1, "debug run");
    debug_mode <= 1'b0;
    $display("test gating done");
  endtask

  task automatic t_count;
    cap_pins <= 6'h1F;
    wr(OFF_CLOCK_CONTROL, {29'h0, SRC_IN0});
    arm(3'b000, 16'h0003);
    rd(OFF_COUNTER_VALUE, 32'h0, "preload up");
    go(3'b000);
    pulse(5);
    rd(OFF_COUNTER_VALUE, 32'h1, "up wrap");
    check(n_max, 32'h1, "max pulse");
    rd(OFF_COUNTER_STATUS, 32'h0000007F, "active up");
    rd(OFF_COUNTER_CONTROL, 32'h5, "run reads 1");
    wr(OFF_COUNTER_CONTROL, 32'h1);
    pulse(2);
    rd(OFF_COUNTER_VALUE, 32'h1, "stopped");
    rd(OFF_COUNTER_CONTROL, 32'h1, "run reads 0");
    arm(3'b010, 16'h0003);
    rd(OFF_COUNTER_VALUE, 32'h3, "preload down");
    go(3'b010);
    pulse(5);
    rd(OFF_COUNTER_VALUE, 32'h2, "down reload");
    check(n_zero, 32'h1, "zero pulse");
    rd(OFF_COUNTER_STATUS, 32'h0000007D, "direction down");
    // Maximum is set before the one-shot run starts and left alone during it
    arm(3'b001, 16'h0003);
    go(3'b001);
    pulse(6);
    rd(OFF_COUNTER_CONTROL, 32'h9, "one-shot end");
    rd(OFF_COUNTER_STATUS, 32'h0000007E, "idle");
    $display("test counting done");
  endtask

  task automatic t_invert;
    wr(OFF_CLOCK_CONTROL, {29'h0, SRC_IN0_N});
    arm(3'b000, 16'h00FF);
    go(3'b000);
    ext_in0 <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(OFF_COUNTER_VALUE, 32'h0, "inverted rise");
    ext_in0 <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(OFF_COUNTER_VALUE, 32'h1, "inverted fall");
    $display("test inverted done");
  endtask

  task automatic t_busy;
    // Stop the counter left running by the previous test
    wr(OFF_COUNTER_CONTROL, 32'h1);
    wr(OFF_MAXIMUM_COUNT, 32'h5);
    rd(OFF_COUNTER_CONTROL, 32'h00000101, "max pending");
    settle();
    rd(OFF_COUNTER_CONTROL, 32'h1, "max done");
    rd(OFF_MAXIMUM_COUNT, 32'h5, "max value");
    $display("test max load done");
  endtask

  task automatic t_div;
    wr(OFF_CLOCK_CONTROL, {29'h0, SRC_IRC});
    arm(3'b000, 16'hFFFF);
    go(3'b000);
    osc_en <= 1'b1;
    rate(38, 45);
    wr(OFF_CLOCK_CONTROL, 32'h00000020);
    rate(9, 12);
    osc_en <= 1'b0;
    // Internal source now idle: only the high-speed input can advance the count
    wr(OFF_CLOCK_CONTROL, 32'h00000012);
    rate(19, 23);
    $display("test divider done");
  endtask

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    osc_irc    = 1'b0;
    osc_en     = 1'b0;
    osc_hs     = 1'b0;
    ext_in0    = 1'b0;
    debug_mode = 1'b0;
    cap_pins   = 6'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_gate();
    t_count();
    t_invert();
    t_busy();
    t_div();
    summarize();
  end
endmodule
`default_nettype wire
